// ### core/host_port_device.sv
`timescale 1ns/10ps
module host_port_device #(
  parameter int DATA_WIDTH = host_port_pkg::DATA_WIDTH,
  parameter int WORD_WIDTH = host_port_pkg::WORD_WIDTH
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  host_port_if.device                port,
  output logic                       fetch_req,
  input  wire logic                  fetch_done,
  input  wire logic [WORD_WIDTH-1:0] fetch_data,
  output logic                       xfer_req,
  output logic                       xfer_write,
  output logic                       xfer_auto,
  output logic [WORD_WIDTH-1:0]      xfer_data,
  input  wire logic                  xfer_done,
  output logic [1:0]                 reg_access_type,
  output logic                       reg_access_valid
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic [5:0] pin_raw;
  logic [DATA_WIDTH-1:0] wd_s1_reg;
  logic [DATA_WIDTH-1:0] wd_s2_reg;
  logic [3:0] sel_s1_reg;
  logic [3:0] sel_s2_reg;

  assign pin_raw = {port.host_chip_select_n, port.host_data_strobe_one,
                    port.host_data_strobe_two, port.host_address_strobe_n,
                    2'h0};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_reg <= 6'h3e;
      pin_s2_reg <= 6'h3e;
      wd_s1_reg  <= '0;
      wd_s2_reg  <= '0;
      sel_s1_reg <= 4'h0;
      sel_s2_reg <= 4'h0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      wd_s1_reg  <= port.host_wdata;
      wd_s2_reg  <= wd_s1_reg;
      sel_s1_reg <= {port.host_access_type, port.host_read_not_write,
                     port.halfword_select};
      sel_s2_reg <= sel_s1_reg;
    end
  end

  logic cs_n;
  logic as_n;
  logic strobe_n;
  assign cs_n = pin_s2_reg[5];
  assign as_n = pin_s2_reg[2];
  assign strobe_n = ~(pin_s2_reg[4] ^ pin_s2_reg[3]) | cs_n;

  // ---------------------------------------------------------------
  // Access control
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_LEAD  = 3'b011,
    ST_OPEN  = 3'b010,
    ST_XFER  = 3'b110
  } state_type;

  state_type             state_reg, state_next;
  logic                  strobe_d_reg, strobe_d_next;
  logic                  as_d_reg, as_d_next;
  logic                  as_seen_reg, as_seen_next;
  logic [3:0]            sel_reg, sel_next;
  logic                  busy_reg, busy_next;
  logic                  oe_reg, oe_next;
  logic [DATA_WIDTH-1:0] rdata_reg, rdata_next;
  logic [WORD_WIDTH-1:0] word_reg, word_next;
  logic                  fetch_reg, fetch_next;
  logic                  xreq_reg, xreq_next;
  logic                  acc_v_reg, acc_v_next;

  function automatic logic needs_xfer(input logic [3:0] s);
    // Data writes and all autoincrement accesses, reads and writes, need a memory transfer.
    needs_xfer = (s[3:2] == host_port_pkg::ACC_DATA_AUTO) ||
                 (s[3:2] == host_port_pkg::ACC_DATA && !s[1]);
  endfunction

  function automatic logic is_data(input logic [3:0] s);
    is_data = (s[3:2] == host_port_pkg::ACC_DATA_AUTO) ||
              (s[3:2] == host_port_pkg::ACC_DATA);
  endfunction

  logic strobe_fall;
  logic strobe_rise;
  logic as_fall;
  logic [3:0] sel_now;
  assign strobe_fall = strobe_d_reg & ~strobe_n;
  assign strobe_rise = ~strobe_d_reg & strobe_n;
  assign as_fall     = as_d_reg & ~as_n;

  always_comb begin
    state_next    = state_reg;
    strobe_d_next = strobe_n;
    as_d_next     = as_n;
    as_seen_next  = as_seen_reg;
    sel_next      = sel_reg;
    busy_next     = busy_reg;
    oe_next       = oe_reg;
    rdata_next    = rdata_reg;
    word_next     = word_reg;
    fetch_next    = 1'b0;
    xreq_next     = 1'b0;
    acc_v_next    = 1'b0;
    sel_now       = sel_reg;
    if (as_fall) begin
      sel_next     = sel_s2_reg;
      as_seen_next = 1'b1;
      if (is_data(sel_s2_reg) && sel_s2_reg[1] && !sel_s2_reg[0]) begin
        busy_next = 1'b1;
      end
    end
    if (strobe_fall) begin
      if (!as_seen_reg && !as_fall) begin
        sel_now  = sel_s2_reg;
        sel_next = sel_s2_reg;
      end else if (as_fall) begin
        sel_now = sel_s2_reg;
      end
      as_seen_next = 1'b0;
      acc_v_next   = ~is_data(sel_now);
      oe_next = sel_now[1];
      if (sel_now[1] && !sel_now[0]) begin
        rdata_next = word_reg[WORD_WIDTH-1:DATA_WIDTH];
      end else if (sel_now[1]) begin
        rdata_next = word_reg[DATA_WIDTH-1:0];
      end
    end
    case (state_reg)
      ST_IDLE: begin
        if (strobe_fall && is_data(sel_now) && sel_now[1] && !sel_now[0]) begin
          fetch_next = 1'b1;
          busy_next  = 1'b1;
          state_next = ST_FETCH;
        end else if (strobe_rise && is_data(sel_reg) && !sel_reg[1] && !sel_reg[0]) begin
          word_next[WORD_WIDTH-1:DATA_WIDTH] = wd_s2_reg;
        end else if (strobe_rise && sel_reg[0] && is_data(sel_reg)) begin
          if (!sel_reg[1]) begin
            word_next[DATA_WIDTH-1:0] = wd_s2_reg;
          end
          if (needs_xfer(sel_reg)) begin
            xreq_next  = 1'b1;
            busy_next  = 1'b1;
            state_next = ST_XFER;
          end
        end
      end
      ST_FETCH: begin
        fetch_next = ~fetch_done;
        if (fetch_done) begin
          word_next  = fetch_data;
          rdata_next = fetch_data[WORD_WIDTH-1:DATA_WIDTH];
          state_next = ST_LEAD;
        end
      end
      ST_LEAD: begin
        // data leads ready by a period
        busy_next  = 1'b0;
        state_next = ST_IDLE;
      end
      ST_XFER: begin
        xreq_next = ~xfer_done;
        if (xfer_done) begin
          busy_next  = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (strobe_rise) begin
      oe_next = 1'b0;
    end
    // address strobe busy only pending fetch
    if (state_reg == ST_IDLE && busy_reg && !as_seen_reg && !fetch_next && !as_fall) begin
      busy_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= ST_IDLE;
      strobe_d_reg <= 1'b1;
      as_d_reg     <= 1'b1;
      as_seen_reg  <= 1'b0;
      sel_reg      <= 4'h0;
      busy_reg     <= 1'b0;
      oe_reg       <= 1'b0;
      rdata_reg    <= host_port_pkg::BUS_RESET;
      word_reg     <= host_port_pkg::WORD_RESET;
      fetch_reg    <= 1'b0;
      xreq_reg     <= 1'b0;
      acc_v_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      strobe_d_reg <= strobe_d_next;
      as_d_reg     <= as_d_next;
      as_seen_reg  <= as_seen_next;
      sel_reg      <= sel_next;
      busy_reg     <= busy_next;
      oe_reg       <= oe_next;
      rdata_reg    <= rdata_next;
      word_reg     <= word_next;
      fetch_reg    <= fetch_next;
      xreq_reg     <= xreq_next;
      acc_v_reg    <= acc_v_next;
    end
  end

  assign port.host_busy_ready_n = busy_reg & ~port.host_chip_select_n;
  assign port.host_rdata        = rdata_reg;
  assign port.host_rdata_oe     = oe_reg;
  assign fetch_req        = fetch_reg;
  assign xfer_req         = xreq_reg;
  assign xfer_write       = ~sel_reg[1];
  assign xfer_auto        = (sel_reg[3:2] == host_port_pkg::ACC_DATA_AUTO);
  assign xfer_data        = word_reg;
  assign reg_access_type  = sel_reg[3:2];
  assign reg_access_valid = acc_v_reg;

endmodule // host_port_device

// ### core/host_port_host.sv
`timescale 1ns/10ps
module host_port_host (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  host_port_if.host        port,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_type,
  input  wire logic        cmd_read,
  input  wire logic [31:0] cmd_wdata,
  output logic [31:0]      rsp_data,
  output logic             rsp_valid
);

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic ready_s1_reg;
  logic ready_s2_reg;
  logic [15:0] rd_s1_reg;
  logic [15:0] rd_s2_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_s1_reg <= 1'b1;
      ready_s2_reg <= 1'b1;
      rd_s1_reg    <= 16'h0000;
      rd_s2_reg    <= 16'h0000;
    end else begin
      ready_s1_reg <= port.host_busy_ready_n;
      ready_s2_reg <= ready_s1_reg;
      rd_s1_reg    <= port.host_rdata;
      rd_s2_reg    <= rd_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_LOW   = 3'b011,
    H_HIGH  = 3'b010
  } hstate_type;

  hstate_type  state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        half_reg, half_next;
  logic [1:0]  type_reg, type_next;
  logic        read_reg, read_next;
  logic [31:0] data_reg, data_next;
  logic        valid_reg, valid_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    half_next  = half_reg;
    type_next  = type_reg;
    read_next  = read_reg;
    data_next  = data_reg;
    valid_next = 1'b0;
    case (state_reg)
      H_IDLE: begin
        if (cmd_valid) begin
          type_next  = cmd_type;
          read_next  = cmd_read;
          data_next  = cmd_wdata;
          half_next  = 1'b0;
          state_next = H_SETUP;
        end
      end
      H_SETUP: begin
        cnt_next   = 4'h0;
        state_next = H_LOW;
      end
      H_LOW: begin
        if (cnt_reg != 4'hf) begin
          cnt_next = cnt_reg + 4'h1;
        end
        if (cnt_reg >= 4'(host_port_pkg::STROBE_LOW_CYCLES + 3) && !ready_s2_reg) begin
          if (read_reg && !half_reg) begin
            data_next[31:16] = rd_s2_reg;
          end else if (read_reg) begin
            data_next[15:0] = rd_s2_reg;
          end
          cnt_next   = 4'h0;
          state_next = H_HIGH;
        end
      end
      H_HIGH: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg >= 4'(host_port_pkg::STROBE_HIGH_CYCLES + 2)) begin
          if (!half_reg) begin
            half_next  = 1'b1;
            state_next = H_SETUP;
          end else begin
            valid_next = 1'b1;
            state_next = H_IDLE;
          end
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= H_IDLE;
      cnt_reg   <= 4'h0;
      half_reg  <= 1'b0;
      type_reg  <= 2'h0;
      read_reg  <= 1'b0;
      data_reg  <= 32'h0000_0000;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      half_reg  <= half_next;
      type_reg  <= type_next;
      read_reg  <= read_next;
      data_reg  <= data_next;
      valid_reg <= valid_next;
    end
  end

  logic active;
  assign active = (state_reg == H_SETUP) || (state_reg == H_LOW) || (state_reg == H_HIGH);
  assign port.host_chip_select_n    = ~active;
  assign port.host_data_strobe_one  = (state_reg == H_LOW);
  assign port.host_data_strobe_two  = 1'b0;
  assign port.host_address_strobe_n = ~((state_reg == H_SETUP) || (state_reg == H_LOW));
  assign port.host_access_type      = type_reg;
  assign port.host_read_not_write   = read_reg;
  assign port.halfword_select       = half_reg;
  assign port.host_wdata            = half_reg ? data_reg[15:0] : data_reg[31:16];
  assign cmd_ready = (state_reg == H_IDLE);
  assign rsp_data  = data_reg;
  assign rsp_valid = valid_reg;

endmodule // host_port_host

// ### core/host_port_if.sv
`timescale 1ns/10ps
interface host_port_if;
  logic        host_chip_select_n;
  logic        host_data_strobe_one;
  logic        host_data_strobe_two;
  logic        host_address_strobe_n;
  logic [1:0]  host_access_type;
  logic        host_read_not_write;
  logic        halfword_select;
  logic        host_busy_ready_n;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic        host_rdata_oe;

  modport device (
    input  host_chip_select_n, host_data_strobe_one, host_data_strobe_two,
    input  host_address_strobe_n, host_access_type, host_read_not_write,
    input  halfword_select, host_wdata,
    output host_busy_ready_n, host_rdata, host_rdata_oe
  );
  modport host (
    output host_chip_select_n, host_data_strobe_one, host_data_strobe_two,
    output host_address_strobe_n, host_access_type, host_read_not_write,
    output halfword_select, host_wdata,
    input  host_busy_ready_n, host_rdata, host_rdata_oe
  );
endinterface

// ### core/host_port_pkg.sv
package host_port_pkg;

  // Access type field codes of the two select bits.
  localparam logic [1:0] ACC_CONTROL   = 2'h0;
  localparam logic [1:0] ACC_DATA_AUTO = 2'h1;
  localparam logic [1:0] ACC_ADDRESS   = 2'h2;
  localparam logic [1:0] ACC_DATA      = 2'h3;

  // Host side timing, in ns and in CPU clock periods.
  localparam int CLK_PERIOD_NS      = 5;
  localparam int STROBE_LOW_NS      = 10;
  localparam int STROBE_HIGH_NS     = 10;
  localparam int STROBE_LOW_CYCLES  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYCLES = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Data is valid about one period before ready falls.
  localparam int DATA_LEAD_NS       = 5;
  localparam int DATA_LEAD_CYCLES   = DATA_LEAD_NS / CLK_PERIOD_NS;

  localparam int DATA_WIDTH = 16;
  localparam int WORD_WIDTH = 32;

  // Reset values.
  localparam logic [15:0] BUS_RESET  = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

endpackage

// ### dv/host_port_sva.sv
`timescale 1ns/10ps
// ----------------------------------------
// Protocol checks on the host port wires.
// ----------------------------------------
module host_port_sva (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        host_chip_select_n,
  input wire logic        host_data_strobe_one,
  input wire logic        host_data_strobe_two,
  input wire logic        host_address_strobe_n,
  input wire logic [1:0]  host_access_type,
  input wire logic        host_read_not_write,
  input wire logic        halfword_select,
  input wire logic        host_busy_ready_n,
  input wire logic [15:0] host_rdata,
  input wire logic        host_rdata_oe
);
  logic acc_on;
  assign acc_on = !host_chip_select_n && (host_data_strobe_one ^ host_data_strobe_two);

  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_gate;
    host_chip_select_n |-> !host_busy_ready_n;
  endproperty
  a_gate: assert property (p_gate) else $error("ready not gated by select");
  property p_oe_start;
    $rose(host_rdata_oe) |-> acc_on && host_read_not_write && $past(acc_on, 2);
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("bus driven outside read");
  property p_oe_end;
    $fell(acc_on) |-> ##[0:5] !host_rdata_oe;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("bus not released");
  property p_lead;
    $fell(host_busy_ready_n) && !host_chip_select_n && host_rdata_oe |-> $stable(host_rdata);
  endproperty
  a_lead: assert property (p_lead) else $error("data not ahead of ready");
  property p_cause;
    $rose(host_busy_ready_n) && $past(!host_chip_select_n) && $past(acc_on)
      |-> host_access_type[0];
  endproperty
  a_cause: assert property (p_cause) else $error("busy on register access");
  property p_fetch;
    $fell(host_address_strobe_n) && !host_chip_select_n && host_read_not_write
      && host_access_type[0] && !halfword_select |-> ##[1:6] host_busy_ready_n;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no busy on data read");
  property p_wbusy;
    $fell(acc_on) && !host_chip_select_n && !host_read_not_write && halfword_select
      && host_access_type[0] |-> ##[1:5] (host_busy_ready_n || host_chip_select_n);
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("no busy after write");
  property p_hold;
    $fell(acc_on) |-> !$past(host_busy_ready_n);
  endproperty
  a_hold: assert property (p_hold) else $error("strobe released while busy");
  property p_width;
    $changed(acc_on) |=> $stable(acc_on);
  endproperty
  a_width: assert property (p_width) else $error("strobe phase too short");
  property p_sel;
    $rose(acc_on) |-> $stable(host_access_type) && $stable(host_read_not_write)
      && $stable(halfword_select);
  endproperty
  a_sel: assert property (p_sel) else $error("selects moved at strobe");
  property p_as;
    $rose(acc_on) |-> !host_address_strobe_n ##1 !host_address_strobe_n;
  endproperty
  a_as: assert property (p_as) else $error("address strobe order");

  c_read: cover property ($fell(host_busy_ready_n) && host_rdata_oe);
  c_write: cover property ($fell(acc_on) && !host_read_not_write && halfword_select);
  c_early: cover property ($fell(host_chip_select_n) && host_busy_ready_n);
endmodule // host_port_sva

// ### dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  typedef struct {
    logic [1:0]  t;
    logic        rd;
    logic [31:0] wd;
    int          nreg;
    int          nxfer;
    logic        busy;
  } row_type;
  row_type rows [8] = '{
    '{2'h0, 1'b0, 32'h0000_1234, 2, 0, 1'b0}, '{2'h0, 1'b1, 32'h0000_0000, 2, 0, 1'b0},
    '{2'h2, 1'b0, 32'h8000_0001, 2, 0, 1'b0}, '{2'h2, 1'b1, 32'h0000_0000, 2, 0, 1'b0},
    '{2'h3, 1'b0, 32'hdead_beef, 0, 1, 1'b1}, '{2'h3, 1'b1, 32'hcafe_f00d, 0, 0, 1'b1},
    '{2'h1, 1'b0, 32'hffff_0000, 0, 1, 1'b1}, '{2'h1, 1'b1, 32'h0000_ffff, 0, 1, 1'b1}};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_type = 2'h0;
  logic        cmd_read = 1'b0;
  logic [31:0] cmd_wdata = 32'h0;
  logic        fetch_done = 1'b0;
  logic        xfer_done = 1'b0;
  logic [31:0] fword = 32'h0;
  logic [31:0] xfer_data, rsp_data, xd;
  logic [1:0]  reg_access_type, lreg;
  logic        fetch_req, xfer_req, xfer_write, xfer_auto, reg_access_valid;
  logic        cmd_ready, rsp_valid, xw, xa;
  int          xlat = 2, flat = 3, xcnt = 0, fcnt = 0;
  int          n_reg, n_xfer, n_busy, miscompares = 0, n_tests = 0;

  host_port_if bus ();
  host_port_device host_port_device_inst (.clk(clk), .sys_rst(sys_rst), .port(bus),
    .fetch_req(fetch_req), .fetch_done(fetch_done), .fetch_data(fword),
    .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_auto(xfer_auto),
    .xfer_data(xfer_data), .xfer_done(xfer_done), .reg_access_type(reg_access_type),
    .reg_access_valid(reg_access_valid));
  host_port_host host_port_host_inst (.clk(clk), .sys_rst(sys_rst), .port(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_type(cmd_type), .cmd_read(cmd_read),
    .cmd_wdata(cmd_wdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
  host_port_sva host_port_sva_inst (.clk(clk), .sys_rst(sys_rst),
    .host_chip_select_n(bus.host_chip_select_n),
    .host_data_strobe_one(bus.host_data_strobe_one),
    .host_data_strobe_two(bus.host_data_strobe_two),
    .host_address_strobe_n(bus.host_address_strobe_n),
    .host_access_type(bus.host_access_type), .host_read_not_write(bus.host_read_not_write),
    .halfword_select(bus.halfword_select), .host_busy_ready_n(bus.host_busy_ready_n),
    .host_rdata(bus.host_rdata), .host_rdata_oe(bus.host_rdata_oe));

  always #2.5 clk = ~clk;

  // ----------------------------------------
  // Memory side responders and monitors.
  // ----------------------------------------
  always @(negedge clk) begin
    xfer_done <= xfer_req === 1'b1 && !xfer_done && xcnt >= xlat;
    xcnt <= (xfer_req === 1'b1 && !xfer_done) ? xcnt + 1 : 0;
    fetch_done <= fetch_req === 1'b1 && !fetch_done && fcnt >= flat;
    fcnt <= (fetch_req === 1'b1 && !fetch_done) ? fcnt + 1 : 0;
  end
  always @(posedge clk) begin
    if (reg_access_valid === 1'b1) begin
      n_reg++;
      lreg = reg_access_type;
    end
    if (xfer_req === 1'b1 && xfer_done) begin
      n_xfer++;
      {xw, xa, xd} = {xfer_write, xfer_auto, xfer_data};
    end
    if (bus.host_chip_select_n === 1'b0 && bus.host_busy_ready_n === 1'b1) n_busy++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic issue(input logic [1:0] t, input logic rd, input logic [31:0] wd);
    while (cmd_ready !== 1'b1) @(negedge clk);
    {cmd_type, cmd_read, cmd_wdata, cmd_valid} = {t, rd, wd, 1'b1};
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic run(input logic [1:0] t, input logic rd, input logic [31:0] wd);
    int n;
    issue(t, rd, wd);
    for (n = 0; n < 500 && rsp_valid !== 1'b1; n++) @(negedge clk);
    if (n == 500) miscompares++;
  endtask
  task automatic clr;
    {n_reg, n_xfer, n_busy} = {32'sd0, 32'sd0, 32'sd0};
  endtask

  // ----------------------------------------
  // Watchdog: the whole run needs far less.
  // ----------------------------------------
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (6) @(negedge clk);
    check(bus.host_busy_ready_n, 1'b0);
    check(bus.host_rdata_oe, 1'b0);
    check(cmd_ready, 1'b1);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      fword = rows[i].wd;
      clr();
      run(rows[i].t, rows[i].rd, rows[i].wd);
      repeat (20) @(negedge clk);
      check(n_reg, rows[i].nreg);
      check(n_xfer, rows[i].nxfer);
      check(n_busy != 0, rows[i].busy);
      if (rows[i].rd && rows[i].t[0]) check(rsp_data, rows[i].wd);
      if (rows[i].nreg != 0) check(lreg, rows[i].t);
      if (rows[i].nxfer != 0) check({xw, xa}, {!rows[i].rd, rows[i].t == 2'h1});
      if (rows[i].nxfer != 0 && !rows[i].rd) check(xd, rows[i].wd);
    end
    xlat = 30;
    run(2'h3, 1'b0, 32'h0f0f_a5a5);
    check(bus.host_busy_ready_n, 1'b0);
    clr();
    run(2'h0, 1'b1, 32'h0);
    check(n_busy != 0, 1'b1);
    check(n_reg, 2);
    xlat = 2;
    flat = 40;
    fword = 32'h1357_9bdf;
    issue(2'h3, 1'b1, 32'h0);
    repeat (15) @(negedge clk);
    check(bus.host_busy_ready_n, 1'b1);
    sys_rst = 1'b1;
    @(negedge clk);
    check({bus.host_chip_select_n, bus.host_busy_ready_n, bus.host_rdata_oe}, 3'b100);
    sys_rst = 1'b0;
    flat = 3;
    run(2'h3, 1'b1, 32'h0);
    check(rsp_data, fword);
    conclude();
  end
endmodule // tb_top
